/* File: logic/tdm_stream_port.sv */
// Stream side of the time-division switch: rates, capacity, bidirectional groups, drive control.
`timescale 1ns/100ps

// Functional notes
// - Thirty-two serial inputs and thirty-two serial outputs, framed by the input pulse.
// - Each stream runs at 2, 4, 8 or 16 Mbps: 32 to 256 channels.
// - Low bidirectional bit ties inputs 0-15 low, outputs 0-15 become bidirectional.
// - High bidirectional bit ties inputs 16-31 low, outputs 16-31 become bidirectional.
// - The two bidirectional groups are set independently of each other.
// - Each input stream rate comes from bits 3-0 of its input control.
// - Each output stream rate comes from bits 3-0 of its own output control.
// - Capacity counts whole streams only; no partial stream can be enabled.
// - High-impedance control outputs exist for outputs 0-15, one per stream, set per channel slot.
// - Control outputs are enabled only with drive pin and outputs-enable bit high.
// - Otherwise, or in reset, controls go high and serial outputs tristate.
// - A control output is high in every unused channel slot of its stream.
// - Clock-rate field 00, 01, 10 selects 16, 8, 4 MHz input clock.
// - Divided mode clocks outputs from the input clock; faster outputs are barred.
// - Divided mode core clock comes from the input clock or the oscillator.
// - Multiplied mode drives outputs from an internal 16 MHz clock, any rate.
// - Master mode loopback bit swaps in internal clock 2 and frame pulse 2.
// - Default falling clock and low frame pulse; polarity bit selects rising clock.
// - Frame position and polarity bits together select GCI frame pulse format.
module tdm_stream_port
   import tdm_stream_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [13:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdData,
   input wire logic frameInClock,
   input wire logic frameInPulse,
   input wire logic outClock2,
   input wire logic outFramePulse2,
   input wire logic outputDriveEnablePin,
   input wire logic [31:0] serialInStreams,
   input wire logic [31:0] serialOutStreamsIn,
   output logic [31:0] serialOutStreamsOut,
   output logic [31:0] serialOutStreamsOe,
   output logic [15:0] extHizCtrlOutputs,
   input wire logic [31:0] coreOutData,
   output logic [31:0] coreInData,
   output logic [31:0] coreBidirData,
   output logic [10:0] frameTickCount,
   output logic frameBoundary,
   output core_clock_type coreClockSource
);

   `include "tdm_stream_consts.svh"

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   // Decodes a rate field into {valid, shift}; channels are 32 shifted left by the shift.
   function automatic logic [2:0] rateDecode(input logic [3:0] code);
      logic [2:0] r;
      r = 3'h0;
      unique case (code)
         `RATE_CODE_2M: r = 3'h4;
         `RATE_CODE_4M: r = 3'h5;
         `RATE_CODE_8M: r = 3'h6;
         `RATE_CODE_16M: r = 3'h7;
         default: r = 3'h0;
      endcase
      return r;
   endfunction : rateDecode

   // Channel count of one whole stream, zero when the stream is unused.
   function automatic logic [13:0] streamChannels(input logic [3:0] code);
      logic [2:0] r;
      r = rateDecode(code);
      return r[2] ? (`BASE_CHANNELS << r[1:0]) : 14'h0000;
   endfunction : streamChannels

   // Highest rate shift that the selected input clock supports.
   function automatic logic [1:0] maxShift(input logic [1:0] clkSel);
      logic [1:0] m;
      m = 2'h0;
      unique case (clkSel)
         2'b00: m = 2'h3;
         2'b01: m = 2'h1;
         default: m = 2'h0;
      endcase
      return m;
   endfunction : maxShift

   // Channel index of a stream at the given tick: scale to the 2048-tick frame first.
   function automatic logic [7:0] channelOf(input logic [10:0] tick, input logic [1:0] clkSel,
                                            input logic [1:0] shift);
      logic [10:0] pos;
      logic [2:0] drop;
      pos = tick << clkSel;
      drop = 3'h6 - {1'b0, shift};
      return 8'(pos >> drop);
   endfunction : channelOf

   // ---------------------------------------------------------------
   // Configuration state
   // ---------------------------------------------------------------
   logic [15:0] ctrlReg;
   logic [15:0] modeReg;
   logic [15:0] next_ctrlReg;
   logic [15:0] next_modeReg;
   logic [15:0] next_regRdData;
   logic [15:0] sinCtrl [0:31];
   logic [15:0] soutCtrl [0:31];
   logic hizMap [0:4095];
   logic sinWrite;
   logic soutWrite;
   logic hizWrite;
   timing_mode_type mode;
   logic [1:0] clkSel;

   // Register writes: scalar registers here, arrays through the decoded strobes.
   always_comb
   begin
      next_ctrlReg = ctrlReg;
      next_modeReg = modeReg;
      if (regWrite && regAddr == `ADDR_CTRL)
         next_ctrlReg = regWrData;
      if (regWrite && regAddr == `ADDR_MODE)
         next_modeReg = regWrData;
      sinWrite = regWrite && regAddr[13:5] == `ADDR_SIN_PAGE;
      soutWrite = regWrite && regAddr[13:5] == `ADDR_SOUT_PAGE;
      hizWrite = regWrite && regAddr[13:12] == `ADDR_HIZMAP_PAGE;
   end

   // Control registers; reset leaves outputs disabled and all streams unused.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ctrlReg <= `CR_RESET;
         modeReg <= `IMS_RESET;
      end
      else
      begin
         ctrlReg <= next_ctrlReg;
         modeReg <= next_modeReg;
      end
   end

   // Per-stream control words and the per-channel drive map of streams 0-15.
   // The map has no reset: a stream only drives once software enabled its rate.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < 32; i++)
         begin
            sinCtrl[i] <= `STREAM_CTRL_RESET;
            soutCtrl[i] <= `STREAM_CTRL_RESET;
         end
      end
      else
      begin
         if (sinWrite)
            sinCtrl[regAddr[4:0]] <= regWrData;
         if (soutWrite)
            soutCtrl[regAddr[4:0]] <= regWrData;
      end
      if (hizWrite)
         hizMap[regAddr[11:0]] <= regWrData[0];
   end

   // Mode decoding; the spare mode code falls back to master.
   always_comb
   begin
      clkSel = ctrlReg[`CR_CLK_RATE_LSB +: 2];
      unique case (modeReg[`IMS_MODE_LSB +: 2])
         2'b01: mode = MODE_DIV_SLAVE;
         2'b10: mode = MODE_MUL_SLAVE;
         default: mode = MODE_MASTER;
      endcase
   end

   // ---------------------------------------------------------------
   // Frame timing
   // ---------------------------------------------------------------
   logic bitTick;
   logic frameStart;
   logic [10:0] tickCount;

   // Timing pins are sampled by clk, so the pin clock must stay below half of clk.
   frame_timing i_frame_timing
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .frameInClock(frameInClock),
      .frameInPulse(frameInPulse),
      .outClock2(outClock2),
      .outFramePulse2(outFramePulse2),
      .clockPolarity(ctrlReg[`CR_CK_POL_BIT]),
      .framePolarity(ctrlReg[`CR_FP_POL_BIT]),
      .framePosition(ctrlReg[`CR_FP_POS_BIT]),
      .loopback(ctrlReg[`CR_LOOPBACK_BIT] && mode == MODE_MASTER),
      .bitTick(bitTick),
      .frameStart(frameStart),
      .tickCount(tickCount)
   );

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [31:0] inMeta;
   logic [31:0] inSync;
   logic [31:0] bidirMeta;
   logic [31:0] bidirSync;
   logic odeMeta;
   logic odeSync;

   // Every pin passes two stages before any logic reads it.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         inMeta <= 32'h00000000;
         inSync <= 32'h00000000;
         bidirMeta <= 32'h00000000;
         bidirSync <= 32'h00000000;
         odeMeta <= 1'b0;
         odeSync <= 1'b0;
      end
      else
      begin
         inMeta <= serialInStreams;
         inSync <= inMeta;
         bidirMeta <= serialOutStreamsIn;
         bidirSync <= bidirMeta;
         odeMeta <= outputDriveEnablePin;
         odeSync <= odeMeta;
      end
   end

   // ---------------------------------------------------------------
   // Capacity and rate checks
   // ---------------------------------------------------------------
   logic [13:0] inTotal;
   logic [13:0] outTotal;
   logic [31:0] outBarred;
   logic inRateBad;
   logic outRateBad;
   logic [2:0] r;

   // Totals are advisory: software keeps them in bounds, hardware only reports them.
   always_comb
   begin
      inTotal = 14'h0000;
      outTotal = 14'h0000;
      inRateBad = 1'b0;
      outRateBad = 1'b0;
      outBarred = 32'h00000000;
      for (int i = 0; i < 32; i++)
      begin
         inTotal = inTotal + streamChannels(sinCtrl[i][`RATE_FIELD_LSB +: 4]);
         outTotal = outTotal + streamChannels(soutCtrl[i][`RATE_FIELD_LSB +: 4]);
         r = rateDecode(sinCtrl[i][`RATE_FIELD_LSB +: 4]);
         if (r[2] && r[1:0] > maxShift(clkSel))
            inRateBad = 1'b1;
         r = rateDecode(soutCtrl[i][`RATE_FIELD_LSB +: 4]);
         // Only divided mode bars outputs faster than the pin clock; master mode flags them, multiplied mode carries any rate.
         if (r[2] && r[1:0] > maxShift(clkSel) && mode == MODE_DIV_SLAVE)
            outBarred[i] = 1'b1;
         if (r[2] && r[1:0] > maxShift(clkSel) && mode == MODE_MASTER)
            outRateBad = 1'b1;
      end
      outRateBad = outRateBad | (|outBarred);
   end

   // ---------------------------------------------------------------
   // Output drive and high-impedance control
   // ---------------------------------------------------------------
   logic outputsOn;
   logic [31:0] drive;
   logic [31:0] next_out;
   logic [31:0] next_oe;
   logic [15:0] next_hiz;
   logic [31:0] next_coreIn;
   logic [31:0] next_coreBidir;
   logic [2:0] rs;
   logic [7:0] chan;
   logic [3:0] sIdx;

   // A stream drives in a slot only when enabled, not barred by divided mode and, for 0-15, mapped used.
   always_comb
   begin
      outputsOn = odeSync && ctrlReg[`CR_OUT_EN_BIT];
      drive = 32'h00000000;
      for (int i = 0; i < 32; i++)
      begin
         rs = rateDecode(soutCtrl[i][`RATE_FIELD_LSB +: 4]);
         drive[i] = outputsOn && rs[2] && !outBarred[i];
         if (i < 16)
         begin
            sIdx = 4'(i);
            chan = channelOf(tickCount, clkSel, rs[1:0]);
            drive[i] = drive[i] && hizMap[{sIdx, chan}];
         end
      end
      next_oe = ~drive;
      next_out = coreOutData & drive;
      next_hiz = ~drive[15:0];
      // Bidirectional groups read their data back from the output pins.
      next_coreIn = inSync;
      next_coreBidir = 32'h00000000;
      if (modeReg[`IMS_BIDIR_LOW_BIT])
      begin
         next_coreIn[15:0] = 16'h0000;
         next_coreBidir[15:0] = bidirSync[15:0];
      end
      if (modeReg[`IMS_BIDIR_HIGH_BIT])
      begin
         next_coreIn[31:16] = 16'h0000;
         next_coreBidir[31:16] = bidirSync[31:16];
      end
   end

   // Pin-facing registers; reset holds every control high and every output released.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         serialOutStreamsOut <= 32'h00000000;
         serialOutStreamsOe <= 32'hFFFFFFFF;
         extHizCtrlOutputs <= 16'hFFFF;
         coreInData <= 32'h00000000;
         coreBidirData <= 32'h00000000;
      end
      else
      begin
         serialOutStreamsOut <= next_out;
         serialOutStreamsOe <= next_oe;
         extHizCtrlOutputs <= next_hiz;
         coreInData <= next_coreIn;
         coreBidirData <= next_coreBidir;
      end
   end

   // ---------------------------------------------------------------
   // Core clock source and frame watchdog
   // ---------------------------------------------------------------
   core_clock_type next_coreClock;
   logic [11:0] lostCount;
   logic [11:0] next_lostCount;
   logic frameLost;
   logic next_frameLost;

   // Divided mode picks the core clock source; multiplied mode uses the internal 16 MHz.
   always_comb
   begin
      unique case (mode)
         MODE_DIV_SLAVE:
            next_coreClock = modeReg[`IMS_OSC_CORE_BIT] ? CORE_CLK_OSC : CORE_CLK_MUL_INPUT;
         MODE_MUL_SLAVE:
            next_coreClock = CORE_CLK_INT16;
         default:
            next_coreClock = CORE_CLK_DPLL;
      endcase
      // Two frame periods without a boundary means the frame pulse has gone.
      if (frameStart)
      begin
         next_lostCount = 12'h000;
         next_frameLost = 1'b0;
      end
      else if (lostCount == 12'(`FRAME_LOST_CYCLES - 1))
      begin
         next_lostCount = lostCount;
         next_frameLost = 1'b1;
      end
      else
      begin
         next_lostCount = lostCount + 12'h001;
         next_frameLost = frameLost;
      end
   end

   // Clock source and watchdog registers.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         coreClockSource <= CORE_CLK_DPLL;
         lostCount <= 12'h000;
         frameLost <= 1'b0;
         frameTickCount <= 11'h000;
         frameBoundary <= 1'b0;
      end
      else
      begin
         coreClockSource <= next_coreClock;
         lostCount <= next_lostCount;
         frameLost <= next_frameLost;
         frameTickCount <= tickCount;
         frameBoundary <= frameStart;
      end
   end

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   // Read data stands in the cycle after the strobe only; unmapped words read zero.
   always_comb
   begin
      next_regRdData = 16'h0000;
      if (regRead)
      begin
         if (regAddr == `ADDR_CTRL)
            next_regRdData = ctrlReg;
         else if (regAddr == `ADDR_MODE)
            next_regRdData = modeReg;
         else if (regAddr == `ADDR_STATUS)
            next_regRdData = {10'h000, bitTick, frameLost, odeSync,
                              inTotal > `CHANNEL_LIMIT || outTotal > `CHANNEL_LIMIT,
                              outRateBad, inRateBad};
         else if (regAddr == `ADDR_IN_TOTAL)
            next_regRdData = {2'h0, inTotal};
         else if (regAddr == `ADDR_OUT_TOTAL)
            next_regRdData = {2'h0, outTotal};
         else if (regAddr[13:5] == `ADDR_SIN_PAGE)
            next_regRdData = sinCtrl[regAddr[4:0]];
         else if (regAddr[13:5] == `ADDR_SOUT_PAGE)
            next_regRdData = soutCtrl[regAddr[4:0]];
         else if (regAddr[13:12] == `ADDR_HIZMAP_PAGE)
            next_regRdData = {15'h0000, hizMap[regAddr[11:0]]};
      end
   end

   // Read data register.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         regRdData <= 16'h0000;
      else
         regRdData <= next_regRdData;
   end

endmodule : tdm_stream_port

/* File: logic/tdm_stream_consts.svh */
// Offsets, field positions, reset values, rate codes and timing counts of the stream port.
`ifndef TDM_STREAM_CONSTS_SVH
`define TDM_STREAM_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets (14-bit word addresses)
// ---------------------------------------------------------------
`define ADDR_CTRL 14'h0000
`define ADDR_MODE 14'h0001
`define ADDR_STATUS 14'h0002
`define ADDR_IN_TOTAL 14'h0003
`define ADDR_OUT_TOTAL 14'h0004
`define ADDR_SIN_PAGE 9'h001
`define ADDR_SOUT_PAGE 9'h002
`define ADDR_HIZMAP_PAGE 2'h1

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CR_OUT_EN_BIT 2
`define CR_CLK_RATE_LSB 5
`define CR_FP_POL_BIT 7
`define CR_CK_POL_BIT 8
`define CR_FP_POS_BIT 9
`define CR_LOOPBACK_BIT 10
`define IMS_MODE_LSB 0
`define IMS_OSC_CORE_BIT 2
`define IMS_BIDIR_LOW_BIT 6
`define IMS_BIDIR_HIGH_BIT 7
`define RATE_FIELD_LSB 0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CR_RESET 16'h0000
`define IMS_RESET 16'h0000
`define STREAM_CTRL_RESET 16'h0000

// ---------------------------------------------------------------
// Rate codes of the four-bit stream rate fields
// ---------------------------------------------------------------
`define RATE_CODE_2M 4'h1
`define RATE_CODE_4M 4'h2
`define RATE_CODE_8M 4'h3
`define RATE_CODE_16M 4'h4

// ---------------------------------------------------------------
// Capacity and timing
// ---------------------------------------------------------------
`define CHANNEL_LIMIT 14'h0800
`define BASE_CHANNELS 14'h0020
`define FRAME_PERIOD_NS 125000
`define CLK_PERIOD_NS 100
`define FRAME_LOST_CYCLES ((2 * `FRAME_PERIOD_NS) / `CLK_PERIOD_NS)

`endif

/* File: logic/tdm_stream_pkg.sv */
// Types shared by the stream port modules.
package tdm_stream_pkg;

   typedef enum logic [1:0]
   {
      MODE_MASTER = 2'b00,
      MODE_DIV_SLAVE = 2'b01,
      MODE_MUL_SLAVE = 2'b10
   } timing_mode_type;

   typedef enum logic [1:0]
   {
      CORE_CLK_DPLL = 2'b00,
      CORE_CLK_MUL_INPUT = 2'b01,
      CORE_CLK_OSC = 2'b10,
      CORE_CLK_INT16 = 2'b11
   } core_clock_type;

endpackage : tdm_stream_pkg

/* File: logic/frame_timing.sv */
// Input clock and frame pulse recovery: synchronise, loop back, polarity and frame count.
`timescale 1ns/100ps

module frame_timing
   import tdm_stream_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic frameInClock,
   input wire logic frameInPulse,
   input wire logic outClock2,
   input wire logic outFramePulse2,
   input wire logic clockPolarity,
   input wire logic framePolarity,
   input wire logic framePosition,
   input wire logic loopback,
   output logic bitTick,
   output logic frameStart,
   output logic [10:0] tickCount
);

   // ---------------------------------------------------------------
   // Synchronisers
   // ---------------------------------------------------------------
   logic [3:0] pinMeta;
   logic [3:0] pinSync;
   logic ckPrev;
   logic pulseSeen;
   logic [10:0] next_tickCount;
   logic next_pulseSeen;
   logic ck;
   logic fp;
   logic pulseActive;
   logic gciFormat;
   logic tick;
   logic boundary;

   // All four pins are asynchronous to clk; the first stage feeds only the second.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pinMeta <= 4'h0;
         pinSync <= 4'h0;
      end
      else
      begin
         pinMeta <= {outFramePulse2, outClock2, frameInPulse, frameInClock};
         pinSync <= pinMeta;
      end
   end

   // ---------------------------------------------------------------
   // Edge and boundary detection
   // ---------------------------------------------------------------
   // The looped-back internal timing replaces the external pins, which are then static.
   always_comb
   begin
      ck = loopback ? pinSync[2] : pinSync[0];
      fp = loopback ? pinSync[3] : pinSync[1];
      pulseActive = framePolarity ? fp : ~fp;
      gciFormat = framePosition & framePolarity;
      tick = clockPolarity ? (ck & ~ckPrev) : (~ck & ckPrev);
      // A standard pulse ends at the boundary; a GCI pulse starts it.
      boundary = tick & (gciFormat ? (pulseActive & ~pulseSeen) : pulseSeen);
      next_pulseSeen = tick ? pulseActive : pulseSeen;
      next_tickCount = boundary ? 11'h000 : (tick ? tickCount + 11'h001 : tickCount);
   end

   // Registers of the frame timeline.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ckPrev <= 1'b0;
         pulseSeen <= 1'b0;
         tickCount <= 11'h000;
         bitTick <= 1'b0;
         frameStart <= 1'b0;
      end
      else
      begin
         ckPrev <= ck;
         pulseSeen <= next_pulseSeen;
         tickCount <= next_tickCount;
         bitTick <= tick;
         frameStart <= boundary;
      end
   end

endmodule : frame_timing

/* File: dv/tdm_stream_port_sva.sv */
// Checker of the stream port pins and core-side outputs.
`timescale 1ns/100ps
module tdm_stream_port_sva
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic outputDriveEnablePin,
   input wire logic [31:0] coreOutData,
   input wire logic [31:0] serialOutStreamsOut,
   input wire logic [31:0] serialOutStreamsOe,
   input wire logic [15:0] extHizCtrlOutputs,
   input wire logic [31:0] coreInData,
   input wire logic [31:0] coreBidirData,
   input wire logic [10:0] frameTickCount,
   input wire logic frameBoundary
);
   // One clock domain, so clocking and disable are declared once.
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   a_reset_all_off: assert property ($past(sys_rst) |-> &serialOutStreamsOe && &extHizCtrlOutputs)
      else $error("outputs live after reset");
   a_pin_low_off: assert property (!outputDriveEnablePin [*5] |-> &serialOutStreamsOe && &extHizCtrlOutputs)
      else $error("outputs live with drive pin low");
   a_out_gated: assert property (serialOutStreamsOut == ($past(coreOutData) & ~serialOutStreamsOe))
      else $error("output data not gated by drive");
   a_hiz_follows_oe: assert property (extHizCtrlOutputs == serialOutStreamsOe[15:0])
      else $error("tristate control differs from drive");
   a_low_group_tied: assert property (|coreBidirData[15:0] |-> coreInData[15:0] == 16'h0000)
      else $error("low inputs not tied in bidirectional mode");
   a_high_group_tied: assert property (|coreBidirData[31:16] |-> coreInData[31:16] == 16'h0000)
      else $error("high inputs not tied in bidirectional mode");
   a_frame_gap: assert property (frameBoundary |=> !frameBoundary [*8])
      else $error("frame boundaries too close");
   a_tick_step: assert property ($changed(frameTickCount) |-> frameTickCount == 11'h000 || frameTickCount == $past(frameTickCount) + 11'h001)
      else $error("tick count skipped");
endmodule : tdm_stream_port_sva

bind tdm_stream_port tdm_stream_port_sva i_tdm_stream_port_sva (.clk(clk), .sys_rst(sys_rst),
   .outputDriveEnablePin(outputDriveEnablePin), .coreOutData(coreOutData),
   .serialOutStreamsOut(serialOutStreamsOut), .serialOutStreamsOe(serialOutStreamsOe),
   .extHizCtrlOutputs(extHizCtrlOutputs), .coreInData(coreInData),
   .coreBidirData(coreBidirData), .frameTickCount(frameTickCount), .frameBoundary(frameBoundary));

/* File: dv/tdm_far_end.sv */
// Far-side model: input clock, frame pulse, serial sources and line drivers.
`timescale 1ns/100ps
module tdm_far_end
(
   input wire logic clk,
   input wire logic loop,
   input wire logic [31:0] oe,
   input wire logic [31:0] dout,
   output logic frameInClock,
   output logic frameInPulse,
   output logic outClock2,
   output logic outFramePulse2,
   output logic [31:0] serialInStreams,
   output logic [31:0] serialOutStreamsIn
);
   logic [8:0] cnt = 9'h000;
   logic pulseBit;
   // A frame is 128 link periods of four cycles; shortened so a run stays brief.
   always_ff @(posedge clk) cnt <= cnt + 9'h001;
   assign pulseBit = (cnt > 9'h001) && (cnt < 9'h1FE);
   // Pins are held static while loopback is selected.
   assign frameInClock = loop ? 1'b0 : cnt[1];
   assign frameInPulse = loop ? 1'b1 : pulseBit;
   assign outClock2 = cnt[1];
   assign outFramePulse2 = pulseBit;
   // Released lines show a changing pattern, never the last driven value.
   assign serialInStreams = {16{cnt[1:0]}};
   assign serialOutStreamsIn = (dout & ~oe) | ({4{cnt[7:0]}} & oe);
endmodule : tdm_far_end

/* File: dv/tdm_stream_port_bench.sv */
// Bench of the stream port: register sequences and line checks.
`timescale 1ns/100ps
`include "tdm_stream_consts.svh"
module tdm_stream_port_bench
   import tdm_stream_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [13:0] regAddr = 14'h0000;
   logic [15:0] regWrData = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic pin = 1'b1;
   logic loop = 1'b0;
   logic [31:0] coreOut = 32'hFFFFFFFF;
   logic [15:0] regRdData, d, hiz;
   logic [31:0] sIn, sOutIn, sOut, sOe, cIn, cBd;
   logic fic, fip, oc2, ofp2, fb;
   logic [10:0] tick;
   core_clock_type src;
   int mismatches = 0;
   int compares = 0;
   int cyc = 0;
   int i, k;
   tdm_stream_port i_tdm_stream_port (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .frameInClock(fic), .frameInPulse(fip), .outClock2(oc2), .outFramePulse2(ofp2),
      .outputDriveEnablePin(pin), .serialInStreams(sIn), .serialOutStreamsIn(sOutIn),
      .serialOutStreamsOut(sOut), .serialOutStreamsOe(sOe), .extHizCtrlOutputs(hiz),
      .coreOutData(coreOut), .coreInData(cIn), .coreBidirData(cBd), .frameTickCount(tick),
      .frameBoundary(fb), .coreClockSource(src));
   tdm_far_end i_tdm_far_end (.clk(clk), .loop(loop), .oe(sOe), .dout(sOut),
      .frameInClock(fic), .frameInPulse(fip), .outClock2(oc2), .outFramePulse2(ofp2),
      .serialInStreams(sIn), .serialOutStreamsIn(sOutIn));
   initial forever #50 clk = ~clk;
   // A hang is cut short well beyond the expected few thousand cycles.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         end_sim();
      end
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task wr(input logic [13:0] a, input logic [15:0] v);
      @(posedge clk);
      regAddr <= a;
      regWrData <= v;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr
   task rc(input logic [13:0] a, input logic [15:0] m, input logic [15:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(negedge clk);
      chk($sformatf("reg %h", a), e, regRdData & m);
   endtask : rc
   task wfb();
      @(negedge clk);
      for (k = 0; k < 2000 && fb !== 1'b1; k++) @(negedge clk);
   endtask : wfb
   task ms(input logic [15:0] m, input core_clock_type e);
      wr(`ADDR_MODE, m);
      repeat (3) @(negedge clk);
      chk("clock source", e, src);
   endtask : ms
   task end_sim();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   initial
   begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rc(`ADDR_CTRL, 16'hFFFF, `CR_RESET);
      rc(`ADDR_MODE, 16'hFFFF, `IMS_RESET);
      rc(14'h0010, 16'hFFFF, 16'h0000);
      chk("hiz", 16'hFFFF, hiz);
      for (i = 0; i < 4; i++) wr(14'(32 + i), 16'(`RATE_CODE_2M + i));
      wr(14'h0024, 16'h0009);
      rc(`ADDR_IN_TOTAL, 16'hFFFF, 16'(`BASE_CHANNELS * 14'h000F));
      rc(`ADDR_OUT_TOTAL, 16'hFFFF, 16'h0000);
      wr(14'h0040, 16'(`RATE_CODE_2M));
      rc(`ADDR_OUT_TOTAL, 16'hFFFF, 16'(`BASE_CHANNELS));
      for (i = 5; i < 16; i++) wr(14'(32 + i), 16'(`RATE_CODE_16M));
      rc(`ADDR_IN_TOTAL, 16'hFFFF, 16'h0CE0);
      rc(`ADDR_STATUS, 16'h0004, 16'h0004);
      // Channel 0 of stream 0 is used, channel 1 is not.
      wr(14'h1000, 16'h0001);
      for (i = 1; i < 64; i++) wr(14'(4096 + i), 16'h0000);
      wr(`ADDR_CTRL, 16'h0004);
      wfb();
      repeat (40) @(negedge clk);
      chk("slot 0", 3'b001, {hiz[0], sOe[0], sOut[0]});
      repeat (260) @(negedge clk);
      chk("slot 1", 2'b11, {hiz[0], sOe[0]});
      @(posedge clk) pin <= 1'b0;
      repeat (6) @(negedge clk);
      chk("pin off", 32'hFFFFFFFF, {hiz, sOe[15:0]});
      @(posedge clk) pin <= 1'b1;
      wr(`ADDR_MODE, 16'h0040);
      repeat (6) @(negedge clk);
      chk("low tied", 32'h00000000, {cIn[15:0], cBd[31:16]});
      wr(`ADDR_MODE, 16'h0080);
      repeat (6) @(negedge clk);
      chk("high tied", 32'h00000000, {cIn[31:16], cBd[15:0]});
      wr(`ADDR_MODE, 16'h0000);
      wr(`ADDR_CTRL, 16'h0404);
      @(posedge clk) loop <= 1'b1;
      wfb();
      chk("loop frame", 2'b10, {fb, oc2});
      @(posedge clk) loop <= 1'b0;
      wr(`ADDR_CTRL, 16'h0384);
      wfb();
      wfb();
      chk("rising frame", 2'b11, {fb, fic});
      wr(`ADDR_CTRL, 16'h0044);
      wr(14'h0040, 16'(`RATE_CODE_4M));
      ms(16'h0001, CORE_CLK_MUL_INPUT);
      rc(`ADDR_STATUS, 16'h0002, 16'h0002);
      ms(16'h0005, CORE_CLK_OSC);
      ms(16'h0002, CORE_CLK_INT16);
      ms(16'h0000, CORE_CLK_DPLL);
      end_sim();
   end
endmodule : tdm_stream_port_bench
